//--- rtl/handshake_pkg.sv
// Shared types and constants for the startup claim handshake block
// ==========================================================
// Functional notes
// - Short-reach port always sends V43 carriers
// - Long-reach port always sends A4 carriers
// - Extra carriers only from permitted list
// - Packet bonding flag equals aggregation available, except in MS
// - Time-division bonding flag always cleared
// - Mode select bonding flag equals aggregation enable
// - Customer request discovery bit equals availability
// - Customer request carries claim, clear bit zero
// - Every CL answered with ACK1
// - Read: one exchange, report received claim
// - Read reply has discovery bit cleared
// - Modify: two exchanges, ignore first claim
// - Set reply: discovery one, clear zero, code
// - Customer loads code only when register clear
// - Clear reply: discovery one, clear one, code
// - Customer clears register only on match
// - Modify reports claim from second exchange
// - Second reply has discovery bit cleared
package handshake_pkg;

  // ==========================================================
  // Widths and carrier permission
  localparam int unsigned CLAIM_W = 16;
  localparam int unsigned EXTRA_W = 8;
  localparam logic [EXTRA_W-1:0] PERMITTED_EXTRA = 8'h3c;
  localparam logic [CLAIM_W-1:0] CLAIM_RESET     = 16'h0000;

  // ==========================================================
  // Message kinds
  typedef enum logic [2:0] {
    MSG_NONE   = 3'h0,
    MSG_MR     = 3'h1,
    MSG_REQCLR = 3'h2,
    MSG_CLR    = 3'h3,
    MSG_CL     = 3'h4,
    MSG_ACK1   = 3'h5,
    MSG_MS     = 3'h6
  } msg_kind_t;

  // Management commands
  typedef enum logic [1:0] {
    CMD_READ  = 2'h1,
    CMD_SET   = 2'h2,
    CMD_CLEAR = 2'h3
  } cmd_t;

  typedef struct packed {
    msg_kind_t          kind;
    logic               discovery;
    logic               bonding;
    logic               tdmBond;
    logic               clearOnMatch;
    logic [CLAIM_W-1:0] claim;
  } hs_msg_t;

  typedef struct packed {
    logic               v43;
    logic               a4;
    logic [EXTRA_W-1:0] extra;
  } tone_t;

  localparam hs_msg_t MSG_RESET = '0;
  localparam tone_t   TONE_RESET = '0;

endpackage

//--- rtl/remote_claim_handshake_access.sv
// Handshake message engine: carriers, claim register and remote access
`timescale 1ns/1ps
module remote_claim_handshake_access (
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                reset,
  // Configuration
  input  wire logic                                isCentralOffice,
  input  wire logic                                shortReach,
  input  wire logic [handshake_pkg::EXTRA_W-1:0]   extraCarrierReq,
  input  wire logic                                aggregationAvailable,
  input  wire logic                                aggregationEnable,
  input  wire logic [handshake_pkg::CLAIM_W-1:0]   localClaimCode,
  // Management commands
  input  wire logic                                cmdValid,
  input  wire handshake_pkg::cmd_t                 cmd,
  input  wire logic                                modeSelectReq,
  input  wire logic                                sessionStart,
  output logic                                     busy,
  output logic                                     done,
  output logic [handshake_pkg::CLAIM_W-1:0]        result,
  // Link partner messages
  input  wire logic                                rxValid,
  input  wire handshake_pkg::hs_msg_t              rxMsg,
  output logic                                     txValid,
  output handshake_pkg::hs_msg_t                   txMsg,
  // Status
  output handshake_pkg::tone_t                     toneOut,
  output logic [handshake_pkg::CLAIM_W-1:0]        claimValue
);

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_WAITCLR = 3'b010,
    ST_WAITACK = 3'b100
  } state_t;

  state_t                            state_r;
  handshake_pkg::cmd_t               cmd_r;
  logic                              pass_r;
  logic                              busy_r;
  logic                              done_r;
  logic [handshake_pkg::CLAIM_W-1:0] result_r;
  logic                              txValid_r;
  handshake_pkg::hs_msg_t            txMsg_r;
  handshake_pkg::tone_t              tone_r;
  logic [handshake_pkg::CLAIM_W-1:0] claim_r;

  logic modify;
  logic lastPass;
  logic rxMr;
  logic rxReqClr;
  logic rxClr;
  logic rxCl;
  logic rxAck;

  // Message builder; time-division bonding never set
  function automatic handshake_pkg::hs_msg_t mk_msg(
    input handshake_pkg::msg_kind_t          kind,
    input logic                              disc,
    input logic                              bond,
    input logic                              com,
    input logic [handshake_pkg::CLAIM_W-1:0] claim
  );
    handshake_pkg::hs_msg_t m;
    m.kind         = kind;
    m.discovery    = disc;
    m.bonding      = bond;
    m.tdmBond      = 1'b0;
    m.clearOnMatch = com;
    m.claim        = claim;
    return m;
  endfunction

  assign modify   = (cmd_r != handshake_pkg::CMD_READ);
  assign lastPass = !modify || pass_r;
  assign rxMr     = rxValid && rxMsg.kind == handshake_pkg::MSG_MR;
  assign rxReqClr = rxValid && rxMsg.kind == handshake_pkg::MSG_REQCLR;
  assign rxClr    = rxValid && rxMsg.kind == handshake_pkg::MSG_CLR;
  assign rxCl     = rxValid && rxMsg.kind == handshake_pkg::MSG_CL;
  assign rxAck    = rxValid && rxMsg.kind == handshake_pkg::MSG_ACK1;

  // ==========================================================
  // Carrier selection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tone_r <= handshake_pkg::TONE_RESET;
    end else begin
      tone_r.v43   <= shortReach;
      tone_r.a4    <= !shortReach;
      // Masked so a bad request can never reach the line
      tone_r.extra <= extraCarrierReq & handshake_pkg::PERMITTED_EXTRA;
    end
  end

  // ==========================================================
  // Central-office command sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r  <= ST_IDLE;
      cmd_r    <= handshake_pkg::CMD_READ;
      pass_r   <= 1'b0;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      result_r <= handshake_pkg::CLAIM_RESET;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          // Commands while busy are ignored, not queued
          if (isCentralOffice && cmdValid) begin
            cmd_r   <= cmd;
            pass_r  <= 1'b0;
            busy_r  <= 1'b1;
            state_r <= ST_WAITCLR;
          end
        end
        ST_WAITCLR: begin
          if (rxClr) begin
            if (lastPass) begin
              result_r <= rxMsg.claim;
            end
            state_r <= ST_WAITACK;
          end
        end
        ST_WAITACK: begin
          if (rxAck) begin
            if (lastPass) begin
              busy_r  <= 1'b0;
              done_r  <= 1'b1;
              state_r <= ST_IDLE;
            end else begin
              pass_r  <= 1'b1;
              state_r <= ST_WAITCLR;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Customer-end claim register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      claim_r <= handshake_pkg::CLAIM_RESET;
    end else if (!isCentralOffice && rxCl && rxMsg.discovery) begin
      if (!rxMsg.clearOnMatch && claim_r == handshake_pkg::CLAIM_RESET) begin
        claim_r <= rxMsg.claim;
      end else if (rxMsg.clearOnMatch && claim_r == rxMsg.claim) begin
        claim_r <= handshake_pkg::CLAIM_RESET;
      end
    end
  end

  // ==========================================================
  // Outgoing messages
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txValid_r <= 1'b0;
      txMsg_r   <= handshake_pkg::MSG_RESET;
    end else begin
      txValid_r <= 1'b0;
      if (isCentralOffice) begin
        if (state_r == ST_WAITCLR && rxMr) begin
          txValid_r <= 1'b1;
          txMsg_r   <= mk_msg(handshake_pkg::MSG_REQCLR, 1'b0,
                              aggregationAvailable, 1'b0,
                              handshake_pkg::CLAIM_RESET);
        end else if (state_r == ST_WAITCLR && rxClr) begin
          txValid_r <= 1'b1;
          // First modify pass carries the code; last pass reads only
          txMsg_r   <= mk_msg(handshake_pkg::MSG_CL, !lastPass,
                              aggregationAvailable,
                              !lastPass && cmd_r == handshake_pkg::CMD_CLEAR,
                              lastPass ? handshake_pkg::CLAIM_RESET
                                       : localClaimCode);
        end else if (state_r == ST_IDLE && rxMr && modeSelectReq) begin
          txValid_r <= 1'b1;
          txMsg_r   <= mk_msg(handshake_pkg::MSG_MS, 1'b0,
                              aggregationEnable, 1'b0,
                              handshake_pkg::CLAIM_RESET);
        end
      end else begin
        if (rxReqClr) begin
          txValid_r <= 1'b1;
          txMsg_r   <= mk_msg(handshake_pkg::MSG_CLR, aggregationAvailable,
                              aggregationAvailable, 1'b0,
                              claim_r);
        end else if (rxCl) begin
          txValid_r <= 1'b1;
          txMsg_r   <= mk_msg(handshake_pkg::MSG_ACK1, 1'b0,
                              aggregationAvailable, 1'b0,
                              handshake_pkg::CLAIM_RESET);
        end else if (sessionStart) begin
          txValid_r <= 1'b1;
          txMsg_r   <= mk_msg(handshake_pkg::MSG_MR, 1'b0,
                              aggregationAvailable, 1'b0,
                              handshake_pkg::CLAIM_RESET);
        end
      end
    end
  end

  assign busy       = busy_r;
  assign done       = done_r;
  assign result     = result_r;
  assign txValid    = txValid_r;
  assign txMsg      = txMsg_r;
  assign toneOut    = tone_r;
  assign claimValue = claim_r;

  // ==========================================================
  // Assertions
  property p_v43;
    @(posedge clk) disable iff (reset) shortReach |=> toneOut.v43;
  endproperty
  a_v43: assert property (p_v43) else $error("V43 missing");

  property p_a4;
    @(posedge clk) disable iff (reset) !shortReach |=> toneOut.a4;
  endproperty
  a_a4: assert property (p_a4) else $error("A4 missing");

  property p_extra;
    @(posedge clk) disable iff (reset)
      (toneOut.extra & ~handshake_pkg::PERMITTED_EXTRA) == '0;
  endproperty
  a_extra: assert property (p_extra) else $error("Bad carrier");

  property p_bond;
    @(posedge clk) disable iff (reset)
      txValid && txMsg.kind != handshake_pkg::MSG_MS
      |-> txMsg.bonding == $past(aggregationAvailable);
  endproperty
  a_bond: assert property (p_bond) else $error("Bonding flag wrong");

  property p_tdm;
    @(posedge clk) disable iff (reset) txValid |-> !txMsg.tdmBond;
  endproperty
  a_tdm: assert property (p_tdm) else $error("Time-division bond set");

  property p_ms;
    @(posedge clk) disable iff (reset)
      txValid && txMsg.kind == handshake_pkg::MSG_MS
      |-> txMsg.bonding == $past(aggregationEnable);
  endproperty
  a_ms: assert property (p_ms) else $error("MS bonding wrong");

  property p_clr;
    @(posedge clk) disable iff (reset)
      txValid && txMsg.kind == handshake_pkg::MSG_CLR
      |-> txMsg.discovery == $past(aggregationAvailable)
          && !txMsg.clearOnMatch && txMsg.claim == $past(claimValue);
  endproperty
  a_clr: assert property (p_clr) else $error("CLR content wrong");

  property p_ack;
    @(posedge clk) disable iff (reset)
      rxCl && !isCentralOffice
      |=> txValid && txMsg.kind == handshake_pkg::MSG_ACK1;
  endproperty
  a_ack: assert property (p_ack) else $error("CL not acked");

  property p_result;
    @(posedge clk) disable iff (reset)
      state_r == ST_WAITCLR && rxClr && lastPass
      |=> result == $past(rxMsg.claim) ##1 1'b1;
  endproperty
  a_result: assert property (p_result) else $error("Result wrong");

  property p_cl;
    @(posedge clk) disable iff (reset)
      state_r == ST_WAITCLR && rxClr
      |=> txValid && txMsg.discovery == !$past(lastPass)
          && txMsg.clearOnMatch ==
             (!$past(lastPass) && cmd_r == handshake_pkg::CMD_CLEAR)
          && txMsg.claim == ($past(lastPass) ? handshake_pkg::CLAIM_RESET
                                             : $past(localClaimCode));
  endproperty
  a_cl: assert property (p_cl) else $error("CL content wrong");

  property p_set;
    @(posedge clk) disable iff (reset)
      !isCentralOffice && rxCl && rxMsg.discovery && !rxMsg.clearOnMatch
      && claimValue != handshake_pkg::CLAIM_RESET
      |=> $stable(claimValue);
  endproperty
  a_set: assert property (p_set) else $error("Claim overwritten");

  property p_clear;
    @(posedge clk) disable iff (reset)
      !isCentralOffice && rxCl && rxMsg.discovery && rxMsg.clearOnMatch
      && claimValue == rxMsg.claim |=> claimValue == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("Claim not cleared");

  property p_one;
    @(posedge clk) disable iff (reset) busy && cmdValid |=> $stable(cmd_r);
  endproperty
  a_one: assert property (p_one) else $error("Command replaced");

  c_read: cover property (@(posedge clk) disable iff (reset)
    done && cmd_r == handshake_pkg::CMD_READ);
  c_set: cover property (@(posedge clk) disable iff (reset)
    done && cmd_r == handshake_pkg::CMD_SET);
  c_clear: cover property (@(posedge clk) disable iff (reset)
    done && cmd_r == handshake_pkg::CMD_CLEAR);
  c_load: cover property (@(posedge clk) disable iff (reset)
    $rose(|claimValue));

endmodule

//--- verif/claim_partner.sv
// Behavioural customer end that answers the block on the message link
`timescale 1ns/1ps
module claim_partner (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // Bench control
  input  wire logic                   kick,
  input  wire logic                   avail,
  input  var  int                     lag,
  // Message link
  input  wire logic                   txValid,
  input  wire handshake_pkg::hs_msg_t txMsg,
  output logic                        rxValid,
  output handshake_pkg::hs_msg_t      rxMsg,
  // Observed replies
  output handshake_pkg::hs_msg_t      clPrev,
  output handshake_pkg::hs_msg_t      clLast,
  output handshake_pkg::hs_msg_t      lastMs,
  output int                          clCount
);
  handshake_pkg::hs_msg_t            got;
  logic                              k;
  logic                              pendMr;
  logic [handshake_pkg::CLAIM_W-1:0] claimReg;

  initial begin
    rxValid = 1'b0;
    rxMsg = '0;
    clPrev = '0;
    clLast = '0;
    lastMs = '0;
    clCount = 0;
    claimReg = '0;
    pendMr = 1'b0;
  end

  // Lag lets the bench try slow and prompt answers
  task automatic send(input handshake_pkg::msg_kind_t kind);
    repeat (lag) @(posedge clk);
    #1;
    rxMsg = '{kind, avail, avail, 1'b0, 1'b0, claimReg};
    rxValid = 1'b1;
  endtask

  // ==========================================================
  // Reply loop
  always begin
    @(posedge clk);
    k = kick;
    #1;
    rxValid = 1'b0;
    // Released bus must not keep looking valid
    rxMsg = ~rxMsg;
    if (reset) begin
      claimReg = '0;
      pendMr = 1'b0;
    end else if (txValid) begin
      got = txMsg;
      case (got.kind)
        handshake_pkg::MSG_REQCLR: send(handshake_pkg::MSG_CLR);
        handshake_pkg::MSG_CL: begin
          clCount++;
          clPrev = clLast;
          clLast = got;
          if (got.discovery && !got.clearOnMatch && claimReg == '0) begin
            claimReg = got.claim;
          end
          if (got.discovery && got.clearOnMatch && claimReg == got.claim) begin
            claimReg = '0;
          end
          send(handshake_pkg::MSG_ACK1);
          pendMr = 1'b1;
        end
        handshake_pkg::MSG_MS: lastMs = got;
        default: ;
      endcase
    end else if (k || pendMr) begin
      pendMr = 1'b0;
      send(handshake_pkg::MSG_MR);
    end
  end
endmodule

//--- verif/tb.sv
// Self-checking bench for the remote claim handshake block
`timescale 1ns/1ps
module tb;
  localparam handshake_pkg::msg_kind_t RQ = handshake_pkg::MSG_REQCLR;
  localparam handshake_pkg::msg_kind_t CR = handshake_pkg::MSG_CLR;
  localparam handshake_pkg::msg_kind_t CL = handshake_pkg::MSG_CL;
  localparam handshake_pkg::msg_kind_t AK = handshake_pkg::MSG_ACK1;

  typedef struct packed {
    logic                              avail;
    handshake_pkg::msg_kind_t          kind;
    logic                              disc;
    logic                              com;
    logic [handshake_pkg::CLAIM_W-1:0] claim;
    handshake_pkg::msg_kind_t          eKind;
    logic [handshake_pkg::CLAIM_W-1:0] eClaimV;
  } row_t;

  // Customer end rows, claim register carried from row to row
  localparam row_t ROWS [7] = '{
    '{1'b1, RQ, 1'b0, 1'b0, 16'h0000, CR, 16'h0000},
    '{1'b1, CL, 1'b1, 1'b0, 16'h1234, AK, 16'h1234},
    '{1'b1, CL, 1'b1, 1'b0, 16'h5678, AK, 16'h1234},
    '{1'b0, RQ, 1'b0, 1'b0, 16'h0000, CR, 16'h1234},
    '{1'b0, CL, 1'b1, 1'b1, 16'h5678, AK, 16'h1234},
    '{1'b1, CL, 1'b1, 1'b1, 16'h1234, AK, 16'h0000},
    '{1'b1, CL, 1'b1, 1'b0, 16'h00c3, AK, 16'h00c3}};

  logic                              clk;
  logic                              reset;
  logic                              isCo;
  logic                              shortReach;
  logic [handshake_pkg::EXTRA_W-1:0] extraReq;
  logic                              avail;
  logic                              aggEnable;
  logic [handshake_pkg::CLAIM_W-1:0] claimCode;
  logic                              cmdValid;
  handshake_pkg::cmd_t               cmd;
  logic                              modeSel;
  logic                              sessStart;
  logic                              busy;
  logic                              done;
  logic [handshake_pkg::CLAIM_W-1:0] result;
  logic                              rxV;
  handshake_pkg::hs_msg_t            rxM;
  logic                              txValid;
  handshake_pkg::hs_msg_t            txMsg;
  handshake_pkg::tone_t              toneOut;
  logic [handshake_pkg::CLAIM_W-1:0] claimValue;
  logic                              useBench;
  logic                              bRxValid;
  handshake_pkg::hs_msg_t            bRxMsg;
  logic                              pRxValid;
  handshake_pkg::hs_msg_t            pRxMsg;
  logic                              kick;
  int                                lag;
  handshake_pkg::hs_msg_t            clPrev;
  handshake_pkg::hs_msg_t            clLast;
  handshake_pkg::hs_msg_t            lastMs;
  int                                clCount;
  int                                mismatches;
  int                                checks;
  row_t                              r;
  logic [handshake_pkg::CLAIM_W-1:0] held;
  int                                n0;

  assign rxV = useBench ? bRxValid : pRxValid;
  assign rxM = useBench ? bRxMsg : pRxMsg;

  remote_claim_handshake_access remote_claim_handshake_access_inst (
    .clk(clk), .reset(reset), .isCentralOffice(isCo),
    .shortReach(shortReach), .extraCarrierReq(extraReq),
    .aggregationAvailable(avail), .aggregationEnable(aggEnable),
    .localClaimCode(claimCode), .cmdValid(cmdValid), .cmd(cmd),
    .modeSelectReq(modeSel), .sessionStart(sessStart), .busy(busy),
    .done(done), .result(result), .rxValid(rxV), .rxMsg(rxM),
    .txValid(txValid), .txMsg(txMsg), .toneOut(toneOut),
    .claimValue(claimValue));

  claim_partner claim_partner_inst (
    .clk(clk), .reset(reset), .kick(kick), .avail(avail), .lag(lag),
    .txValid(txValid), .txMsg(txMsg), .rxValid(pRxValid),
    .rxMsg(pRxMsg), .clPrev(clPrev), .clLast(clLast), .lastMs(lastMs),
    .clCount(clCount));

  always #50 clk = ~clk;

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic co_op(input handshake_pkg::cmd_t c,
                       input logic [15:0] code, input int l,
                       input logic [15:0] expR);
    int w;
    n0 = clCount;
    lag = l;
    claimCode = code;
    cmd = c;
    cmdValid = 1'b1;
    kick = 1'b1;
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    kick = 1'b0;
    check(busy, 1'b1);
    // A command while busy must be ignored
    cmd = handshake_pkg::CMD_CLEAR;
    cmdValid = 1'b1;
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    w = 0;
    while (done !== 1'b1 && w < 300) begin
      @(posedge clk);
      #1;
      w++;
    end
    check({done, busy}, 2'b10);
    check(result, expR);
    check(clCount - n0, (c == handshake_pkg::CMD_READ) ? 1 : 2);
    check({clLast.discovery, clLast.bonding, clLast.tdmBond},
          {1'b0, avail, 1'b0});
    if (c != handshake_pkg::CMD_READ) begin
      check({clPrev.discovery, clPrev.clearOnMatch, clPrev.claim},
            {1'b1, c == handshake_pkg::CMD_CLEAR, code});
    end
    repeat (l + 6) @(posedge clk);
    #1;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clk = 0; reset = 1; isCo = 0; shortReach = 0; extraReq = 8'h00;
    avail = 0; aggEnable = 0; claimCode = '0; cmdValid = 0;
    cmd = handshake_pkg::CMD_READ; modeSel = 0; useBench = 1; sessStart = 0;
    bRxValid = 0; bRxMsg = '0; kick = 0; lag = 0; held = '0;
    mismatches = 0; checks = 0;
    fork
      begin
        #300000;
        mismatches++;
        wrap_up();
      end
    join_none
    repeat (10) @(posedge clk);
    #1;
    check({busy, done, txValid, claimValue}, '0);
    reset = 0;
    for (int s = 0; s < 2; s++) begin
      shortReach = s[0];
      extraReq = 8'hff;
      repeat (2) @(posedge clk);
      #1;
      check({toneOut.v43, toneOut.a4}, {s[0], ~s[0]});
      check(toneOut.extra, 8'hff & handshake_pkg::PERMITTED_EXTRA);
    end
    for (int i = 0; i < 7; i++) begin
      r = ROWS[i];
      avail = r.avail;
      bRxMsg = '{r.kind, r.disc, 1'b0, 1'b0, r.com, r.claim};
      bRxValid = 1;
      @(posedge clk);
      #1;
      bRxValid = 0;
      bRxMsg = ~bRxMsg;
      // Reply stands for one cycle only
      check({txValid, txMsg.kind}, {1'b1, r.eKind});
      check({txMsg.bonding, txMsg.tdmBond}, {r.avail, 1'b0});
      if (r.eKind == CR) begin
        check({txMsg.discovery, txMsg.clearOnMatch, txMsg.claim},
              {r.avail, 1'b0, held});
      end
      check(claimValue, r.eClaimV);
      held = r.eClaimV;
      @(posedge clk);
      #1;
    end
    // Customer end: own start request, commands refused
    sessStart = 1;
    cmdValid = 1;
    @(posedge clk);
    #1;
    sessStart = 0;
    cmdValid = 0;
    check({txValid, txMsg.kind}, {1'b1, handshake_pkg::MSG_MR});
    check(busy, 1'b0);
    @(posedge clk);
    #1;
    // Mid-run reset wipes the claim register
    reset = 1;
    #1;
    check(claimValue, 16'h0000);
    @(posedge clk);
    #1;
    reset = 0;
    useBench = 0;
    isCo = 1;
    avail = 1;
    co_op(handshake_pkg::CMD_READ, 16'h0f0f, 0, 16'h0000);
    co_op(handshake_pkg::CMD_SET, 16'h00a5, 3, 16'h00a5);
    co_op(handshake_pkg::CMD_SET, 16'h0f0f, 0, 16'h00a5);
    co_op(handshake_pkg::CMD_CLEAR, 16'h0f0f, 2, 16'h00a5);
    co_op(handshake_pkg::CMD_CLEAR, 16'h00a5, 0, 16'h0000);
    modeSel = 1;
    for (int e = 0; e < 2; e++) begin
      aggEnable = e[0];
      kick = 1;
      @(posedge clk);
      #1;
      kick = 0;
      repeat (6) @(posedge clk);
      #1;
      check({lastMs.kind, lastMs.bonding, lastMs.tdmBond},
            {handshake_pkg::MSG_MS, e[0], 1'b0});
    end
    wrap_up();
  end
endmodule
